// [pulse_timer_pkg.sv]
// Constants, register map and cell layout for the pulse timer bank
`default_nettype none

package pulse_timer_pkg;

    // Bank geometry
    localparam int NUM_TIMERS = 256;
    localparam int IDX_W = 8;
    localparam int CELL_W = 16;
    localparam int VALUE_W = 10;
    localparam int BCD_W = 12;
    localparam int BASE_W = 2;
    localparam int NUM_BASES = 4;

    // Time base codes
    localparam logic [1:0] BASE_10MS = 2'h0;
    localparam logic [1:0] BASE_100MS = 2'h1;
    localparam logic [1:0] BASE_1S = 2'h2;
    localparam logic [1:0] BASE_10S = 2'h3;

    // Timing: the 10 ms tick from the 100 MHz clock, decades above it
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_BASE_NS = 10_000_000;
    localparam int TICK_BASE_CYCLES = TICK_BASE_NS / CLK_PERIOD_NS;
    localparam logic [3:0] DECADE_LAST = 4'h9;

    // Duration requests, in 10 ms units
    localparam int DUR_W = 20;
    localparam logic [19:0] RANGE_10MS_MAX = 20'h003E7;   // 999
    localparam logic [19:0] RANGE_100MS_MAX = 20'h0270F;  // 9999
    localparam logic [19:0] RANGE_1S_MAX = 20'h1869F;     // 99999
    localparam logic [19:0] DURATION_MAX = 20'hF3E58;     // 9990 s
    localparam logic [19:0] DIV_100MS = 20'h0000A;
    localparam logic [19:0] DIV_1S = 20'h00064;
    localparam logic [19:0] DIV_10S = 20'h003E8;
    localparam logic [9:0] VALUE_ONE = 10'h001;

    // Register map (byte addresses)
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_SELECT = 8'h00;
    localparam logic [7:0] ADDR_CELL = 8'h04;
    localparam logic [7:0] ADDR_DURATION = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_PLAIN = 8'h10;
    localparam logic [7:0] ADDR_REMAIN = 8'h14;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timer word and preset cell share one layout
    typedef struct packed {
        logic [1:0] spare;
        logic [1:0] base;
        logic [11:0] value;
    } timer_cell_t;

endpackage : pulse_timer_pkg

`default_nettype wire

// [pulse_timer_cell.sv]
// Bank of pulse timers with shared prescaler and AXI4-Lite register access
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module pulse_timer_cell #(
    parameter int TICK_CYCLES = pulse_timer_pkg::TICK_BASE_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [pulse_timer_pkg::NUM_TIMERS-1:0] trigger,
    input wire logic [pulse_timer_pkg::NUM_TIMERS-1:0] kill,
    output logic [pulse_timer_pkg::NUM_TIMERS-1:0] timer_running,
    input wire logic [pulse_timer_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pulse_timer_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    localparam int N = pulse_timer_pkg::NUM_TIMERS;
    localparam int PRE_W = $clog2(TICK_CYCLES + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

    // Binary 0..999 to three BCD digits
    function automatic logic [11:0] bin_to_bcd(input logic [9:0] v);
        return {4'(v / 10'd100), 4'((v / 10'd10) % 10'd10), 4'(v % 10'd10)};
    endfunction : bin_to_bcd

    // Three BCD digits to binary; bad digits simply wrap
    function automatic logic [9:0] bcd_to_bin(input logic [11:0] d);
        return 10'(d[11:8]) * 10'd100 + 10'(d[7:4]) * 10'd10 + 10'(d[3:0]);
    endfunction : bcd_to_bin

    // Duration in 10 ms units to a cell: finest base that fits, truncated
    function automatic pulse_timer_pkg::timer_cell_t encode_duration(
        input logic [19:0] dur
    );
        logic [19:0] d;
        logic [19:0] q;
        pulse_timer_pkg::timer_cell_t c;
        d = (dur > pulse_timer_pkg::DURATION_MAX) ?
            pulse_timer_pkg::DURATION_MAX : dur;
        c = '0;
        if (d <= pulse_timer_pkg::RANGE_10MS_MAX) begin
            q = d;
            c.base = pulse_timer_pkg::BASE_10MS;
        end else if (d <= pulse_timer_pkg::RANGE_100MS_MAX) begin
            q = d / pulse_timer_pkg::DIV_100MS;
            c.base = pulse_timer_pkg::BASE_100MS;
        end else if (d <= pulse_timer_pkg::RANGE_1S_MAX) begin
            q = d / pulse_timer_pkg::DIV_1S;
            c.base = pulse_timer_pkg::BASE_1S;
        end else begin
            q = d / pulse_timer_pkg::DIV_10S;
            c.base = pulse_timer_pkg::BASE_10S;
        end
        c.value = bin_to_bcd(q[9:0]);
        return c;
    endfunction : encode_duration

    // Storage: preset cells written by software, live timer words
    pulse_timer_pkg::timer_cell_t preset_cell [N];
    pulse_timer_pkg::timer_cell_t timer_word [N];
    logic [N-1:0] running;
    logic [N-1:0] trig_q;
    logic [N-1:0] kill_q;
    logic [N-1:0] start_pend;
    logic [N-1:0] kill_pend;
    logic [N-1:0] svc_mask;
    logic [pulse_timer_pkg::IDX_W-1:0] scan_ptr;
    logic scan_wrap;

    // Prescaler and tick bookkeeping
    logic [PRE_W-1:0] pre_cnt;
    logic [3:0] decade [3];
    logic [pulse_timer_pkg::NUM_BASES-1:0] tick;
    logic [pulse_timer_pkg::NUM_BASES-1:0] tick_acc;
    logic [pulse_timer_pkg::NUM_BASES-1:0] sweep_ticks;

    // Service of the timer under the scan pointer
    pulse_timer_pkg::timer_cell_t cur_word;
    pulse_timer_pkg::timer_cell_t cur_preset;
    pulse_timer_pkg::timer_cell_t next_word;
    logic next_run;

    // Register interface state
    logic [pulse_timer_pkg::IDX_W-1:0] sel_idx;
    logic aw_held;
    logic w_held;
    logic [pulse_timer_pkg::ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic [31:0] read_mux;
    logic read_ok;
    pulse_timer_pkg::timer_cell_t sel_word;

    assign timer_running = running;
    assign scan_wrap = (scan_ptr == pulse_timer_pkg::IDX_W'(N - 1));
    assign svc_mask = N'(1) << scan_ptr;

    // Base tick every 10 ms, decades give 100 ms, 1 s and 10 s
    always_comb begin
        tick[0] = (pre_cnt == PRE_LAST);
        tick[1] = tick[0] && (decade[0] == pulse_timer_pkg::DECADE_LAST);
        tick[2] = tick[1] && (decade[1] == pulse_timer_pkg::DECADE_LAST);
        tick[3] = tick[2] && (decade[2] == pulse_timer_pkg::DECADE_LAST);
    end

    // Shared prescaler counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_cnt <= '0;
        end else if (ce) begin
            pre_cnt <= tick[0] ? '0 : pre_cnt + PRE_W'(1);
        end
    end

    // Decade dividers, one per step up in time base
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 3; i++) begin
                decade[i] <= '0;
            end
        end else if (ce) begin
            for (int i = 0; i < 3; i++) begin
                if (tick[i + 1]) begin
                    decade[i] <= '0;
                end else if (tick[i]) begin
                    decade[i] <= decade[i] + 4'h1;
                end
            end
        end
    end

    // Ticks gathered during a sweep are applied during the next one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_acc <= '0;
            sweep_ticks <= '0;
        end else if (ce) begin
            if (scan_wrap) begin
                tick_acc <= '0;
                sweep_ticks <= tick_acc | tick;
            end else begin
                tick_acc <= tick_acc | tick;
            end
        end
    end

    // Scan pointer visits every timer once per 256 cycles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scan_ptr <= '0;
        end else if (ce) begin
            scan_ptr <= scan_ptr + pulse_timer_pkg::IDX_W'(1);
        end
    end

    // Edge capture; a new edge wins over the clear of its service slot
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_q <= '0;
            kill_q <= '0;
            start_pend <= '0;
            kill_pend <= '0;
        end else if (ce) begin
            trig_q <= trigger;
            kill_q <= kill;
            start_pend <= (start_pend & ~svc_mask)
                | (trigger & ~trig_q);
            kill_pend <= (kill_pend & ~svc_mask) | (kill & ~kill_q);
        end
    end

    // Next state of the serviced timer
    always_comb begin
        cur_word = timer_word[scan_ptr];
        cur_preset = preset_cell[scan_ptr];
        next_word = cur_word;
        next_run = running[scan_ptr];
        if (kill_pend[scan_ptr] && running[scan_ptr]) begin
            next_word = '0;
            next_run = 1'b0;
        end else if (start_pend[scan_ptr]) begin
            // Kill without a running timer falls through untouched
            next_word = '0;
            next_word.base = cur_preset.base;
            next_word.value = 12'(bcd_to_bin(cur_preset.value));
            next_run = (next_word.value != '0)
                && trigger[scan_ptr];
        end else if (running[scan_ptr] && !trigger[scan_ptr]) begin
            next_run = 1'b0;
        end else if (running[scan_ptr]
                && sweep_ticks[cur_word.base]) begin
            next_word.value = cur_word.value - 12'(1);
            if (cur_word.value[9:0] <= pulse_timer_pkg::VALUE_ONE) begin
                next_word.value = '0;
                next_run = 1'b0;
            end
        end
    end

    // Timer word and running flag update
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < N; i++) begin
                timer_word[i] <= '0;
            end
            running <= '0;
        end else if (ce) begin
            timer_word[scan_ptr] <= next_word;
            running[scan_ptr] <= next_run;
        end
    end

    // Write and read address channel readiness; frozen while ce is low
    assign s_axi_awready = ce && !aw_held;
    assign s_axi_wready = ce && !w_held;
    assign s_axi_arready = ce && !s_axi_rvalid;
    assign do_write = ce && aw_held && w_held && !s_axi_bvalid;

    // Address and data are held separately until both are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // Register writes and write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_idx <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pulse_timer_pkg::RESP_OKAY;
            for (int i = 0; i < N; i++) begin
                preset_cell[i] <= '0;
            end
        end else if (ce) begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= pulse_timer_pkg::RESP_OKAY;
                unique case (aw_addr)
                    pulse_timer_pkg::ADDR_SELECT: begin
                        if (w_strb[0]) begin
                            sel_idx <= w_data[7:0];
                        end
                    end
                    pulse_timer_pkg::ADDR_CELL: begin
                        if (w_strb[0]) begin
                            preset_cell[sel_idx][7:0] <= w_data[7:0];
                        end
                        if (w_strb[1]) begin
                            preset_cell[sel_idx][15:8] <= w_data[15:8];
                        end
                    end
                    pulse_timer_pkg::ADDR_DURATION: begin
                        if (w_strb != '0) begin
                            preset_cell[sel_idx] <=
                                encode_duration(w_data[19:0]);
                        end
                    end
                    default: begin
                        s_axi_bresp <= pulse_timer_pkg::RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // Read view of the selected timer
    always_comb begin
        sel_word = timer_word[sel_idx];
        read_ok = 1'b1;
        read_mux = '0;
        unique case (s_axi_araddr)
            pulse_timer_pkg::ADDR_SELECT: read_mux[7:0] = sel_idx;
            pulse_timer_pkg::ADDR_CELL: read_mux[15:0] = preset_cell[sel_idx];
            pulse_timer_pkg::ADDR_DURATION: read_mux = '0;
            pulse_timer_pkg::ADDR_STATUS: read_mux[0] = running[sel_idx];
            pulse_timer_pkg::ADDR_PLAIN: begin
                read_mux[9:0] = sel_word.value[9:0];
            end
            pulse_timer_pkg::ADDR_REMAIN: begin
                read_mux[13:12] = sel_word.base;
                read_mux[11:0] = bin_to_bcd(sel_word.value[9:0]);
            end
            default: read_ok = 1'b0;
        endcase
    end

    // Read data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= pulse_timer_pkg::RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= read_mux;
                s_axi_rresp <= read_ok ? pulse_timer_pkg::RESP_OKAY
                                       : pulse_timer_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : pulse_timer_cell

`default_nettype wire

// [pulse_timer_props.sv]
// Port-level checks for the pulse timer bank
`timescale 1ns/100ps
`default_nettype none
module pulse_timer_props #(
    parameter int TICK_CYCLES = 600
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [pulse_timer_pkg::NUM_TIMERS-1:0] trigger,
    input wire logic [pulse_timer_pkg::NUM_TIMERS-1:0] kill,
    input wire logic [pulse_timer_pkg::NUM_TIMERS-1:0] timer_running,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pulse_timer_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Timer under watch; service slot plus output flop bounds reactions
    localparam int W = 5;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_start_level: assert property (
        $rose(timer_running[W]) |-> $past(trigger[W]))
        else $error("timer started without trigger high");
    a_trig_drop: assert property (
        $fell(trigger[W]) |-> ##[1:258] (!timer_running[W] || trigger[W]))
        else $error("timer still running after trigger low");
    a_kill_stop: assert property (
        $rose(kill[W]) && timer_running[W] |-> ##[1:258] !timer_running[W])
        else $error("kill edge did not stop timer");
    a_ce_freeze: assert property (
        !ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
        else $error("ready high with clock enable low");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped early");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_bad_read: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == 8'hFC |=> s_axi_rresp ==
        pulse_timer_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    c_start: cover property ($rose(timer_running[W]));
    c_kill: cover property ($rose(kill[W]) && timer_running[W]);
    c_drop: cover property ($fell(timer_running[W]) && !trigger[W]);
endmodule : pulse_timer_props
`default_nettype wire

// [plc_model.sv]
// Controller logic model driving trigger and kill lines
`timescale 1ns/100ps
`default_nettype none
module plc_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [255:0] trig_set,
    input wire logic [255:0] kill_set,
    output logic [255:0] trigger,
    output logic [255:0] kill
);
    // Program scan result registered once per clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trigger <= '0;
            kill <= '0;
        end else begin
            trigger <= trig_set;
            kill <= kill_set;
        end
    end
endmodule : plc_model
`default_nettype wire

// [pulse_timer_cell_tb.sv]
// Self-checking bench for the pulse timer bank
`timescale 1ns/100ps
`default_nettype none
module pulse_timer_cell_tb;
    localparam int TK = 600;
    logic aclk = 0;
    logic aresetn = 0;
    logic ce = 1;
    logic [255:0] trig_set = '0, kill_set = '0;
    logic [255:0] trigger, kill, timer_running;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [65:0] exp_r[$];
    logic [1:0] exp_b[$];
    logic [65:0] x;
    logic [19:0] dur[7] = '{20'h003E7, 20'h003E8, 20'h0270F, 20'h03039,
        20'h1869F, 20'h1E240, 20'hFFFFF};
    logic [15:0] cel[7] = '{16'h0999, 16'h1100, 16'h1999, 16'h2123,
        16'h2999, 16'h3123, 16'h3999};
    logic [15:0] rc;
    int errors = 0, checks = 0;
    int n, cnt;

    always #5 aclk = ~aclk;

    pulse_timer_cell #(.TICK_CYCLES(TK)) dut (.*);
    plc_model plc (.*);

    task automatic end_of_test();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test

    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("Error t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : cmp

    task automatic tmo(input logic ok);
        if (!ok) begin
            errors++;
            $display("Error t=%0t exp=%h got=%h", $time, 1'b1, ok);
            end_of_test();
        end
    endtask : tmo

    // Bus master: write and read, each waits for its answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] r = pulse_timer_pkg::RESP_OKAY);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        exp_b.push_back(r);
        for (n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 0;
        tmo(n < 200);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m = '1,
        input logic [1:0] r = pulse_timer_pkg::RESP_OKAY);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        exp_r.push_back({r, m, e & m});
        for (n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 0;
        tmo(n < 200);
    endtask : rd

    task automatic wait_run(input int i, input logic lvl);
        for (n = 0; n < 300; n++) begin
            @(posedge aclk);
            if (timer_running[i] === lvl) break;
        end
        checks++;
        tmo(n < 300);
    endtask : wait_run

    // Length of one running pulse against its bounds
    task automatic span(input int i, input int lo, input int hi);
        wait_run(i, 1);
        for (cnt = 0; timer_running[i] === 1 && cnt < hi + 20; cnt++)
            @(posedge aclk);
        checks++;
        if (cnt < lo || cnt > hi) begin
            errors++;
            $display("Error t=%0t exp=%h got=%h", $time, hi, cnt);
        end
    endtask : span

    // Answer watcher: oldest note against each response
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready)
            cmp({30'h0, exp_b.pop_front()}, {30'h0, s_axi_bresp});
        if (s_axi_rvalid && s_axi_rready) begin
            x = exp_r.pop_front();
            cmp(x[31:0], s_axi_rdata & x[63:32]);
            cmp({30'h0, x[65:64]}, {30'h0, s_axi_rresp});
        end
    end

    // Main sequence
    initial begin
        void'($urandom(12684));
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        for (int a = 0; a < 24; a += 4) rd(a[7:0], 32'h0);
        rd(8'hFC, 32'h0, '1, pulse_timer_pkg::RESP_SLVERR);
        wr(8'hFC, 32'h1, pulse_timer_pkg::RESP_SLVERR);
        wr(pulse_timer_pkg::ADDR_SELECT, 32'h1FF);
        rd(pulse_timer_pkg::ADDR_SELECT, 32'hFF);
        for (int i = 0; i < 7; i++) begin
            wr(pulse_timer_pkg::ADDR_DURATION, {12'h0, dur[i]});
            rd(pulse_timer_pkg::ADDR_CELL, cel[i], 32'h3FFF);
        end
        for (int i = 0; i < 6; i++) begin
            rc = 16'($urandom);
            wr(pulse_timer_pkg::ADDR_SELECT, $urandom % 256);
            wr(pulse_timer_pkg::ADDR_CELL, {16'h0, rc});
            rd(pulse_timer_pkg::ADDR_CELL, {16'h0, rc});
        end
        wr(pulse_timer_pkg::ADDR_SELECT, 32'h5);
        wr(pulse_timer_pkg::ADDR_CELL, 32'h0999);
        trig_set[5] <= 1;
        wait_run(5, 1);
        rd(pulse_timer_pkg::ADDR_PLAIN, 32'h3E6, 32'hFFFFFFFE);
        rd(pulse_timer_pkg::ADDR_REMAIN, 32'h998, 32'hFFFFFFFE);
        rd(pulse_timer_pkg::ADDR_STATUS, 32'h1);
        ce <= 0;
        repeat (20) @(posedge aclk);
        ce <= 1;
        kill_set[5] <= 1;
        wait_run(5, 0);
        rd(pulse_timer_pkg::ADDR_REMAIN, 32'h0);
        rd(pulse_timer_pkg::ADDR_PLAIN, 32'h0);
        trig_set[5] <= 0;
        repeat (300) @(posedge aclk);
        trig_set[5] <= 1;
        wait_run(5, 1);
        trig_set[5] <= 0;
        wait_run(5, 0);
        rd(pulse_timer_pkg::ADDR_PLAIN, 32'h200, 32'h200);
        kill_set[5] <= 0;
        wr(pulse_timer_pkg::ADDR_SELECT, 32'h7);
        wr(pulse_timer_pkg::ADDR_CELL, 32'h0003);
        trig_set[7] <= 1;
        span(7, 2 * TK - 300, 3 * TK + 600);
        rd(pulse_timer_pkg::ADDR_PLAIN, 32'h0);
        repeat (1000) @(posedge aclk);
        cmp(32'h0, {31'h0, timer_running[7]});
        trig_set[7] <= 0;
        wr(pulse_timer_pkg::ADDR_SELECT, 32'h9);
        wr(pulse_timer_pkg::ADDR_CELL, 32'h1002);
        trig_set[9] <= 1;
        span(9, 10 * TK - 300, 20 * TK + 600);
        rd(pulse_timer_pkg::ADDR_REMAIN, 32'h1000);
        end_of_test();
    end
endmodule : pulse_timer_cell_tb

bind pulse_timer_cell pulse_timer_props #(.TICK_CYCLES(TICK_CYCLES)) chk (.*);
`default_nettype wire
